//--- hw/seb_pkg.sv
// shared constants, types and register map of the serial memory bus slave
package seb_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // clock and write cycle timing
   localparam int CLK_HZ = 25_000_000;
   localparam int TW_MS = 5;
   // longest write time, whole cycles
   localparam int TW_CYCLES = TW_MS * (CLK_HZ / 1000);
   localparam int TWCNT_W = 17;

   ////////////////////////////////////////////////////////////////////////////
   // array geometry
   localparam int MEM_DEPTH = 512;
   localparam int ADDR_W = 9;
   localparam int PAGE_BYTES = 16;
   localparam int PTR_W = 4;

   ////////////////////////////////////////////////////////////////////////////
   // select byte layout
   localparam int SEL_DIR_BIT = 0;
   localparam int SEL_TOP_BIT = 1;
   localparam int SEL_CE_LOW_BIT = 2;
   localparam int SEL_CE_HIGH_BIT = 3;
   localparam int SEL_TYPE_LSB = 4;

   ////////////////////////////////////////////////////////////////////////////
   // wishbone register map, byte offsets
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_MADDR = 4'h8;
   localparam logic [3:0] REG_MDATA = 4'hc;
   localparam int CTRL_FIVE_PIN_BIT = 0;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_ACTIVE_BIT = 1;
   localparam int STAT_WINH_BIT = 2;
   localparam logic CTRL_FIVE_PIN_RESET = 1'b0;
   localparam logic [8:0] MADDR_RESET = 9'h000;

   ////////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK, ST_BUSY} seb_fsm_t;
   typedef enum logic [1:0] {K_SELECT, K_ADDR, K_DATA} seb_kind_t;

   typedef struct packed {
      logic scl;
      logic sda;
      logic strap_high;
      logic strap_low;
      logic winh;
   } seb_pins_t;

   typedef struct packed {
      seb_fsm_t st;
      seb_kind_t kind;
      logic [3:0] bitcnt;
      logic [7:0] shreg;
      logic rd;
      logic ack_ok;
      logic [ADDR_W-1:0] addr;
      logic [PTR_W-1:0] wptr;
      logic [PAGE_BYTES-1:0] pvalid;
      logic [PAGE_BYTES-1:0][7:0] pbuf;
      logic arm;
      logic [TWCNT_W-1:0] twcnt;
      logic scl_q;
      logic sda_q;
      logic sda_drive;
      logic sda_level;
      logic five_pin;
      logic [ADDR_W-1:0] maddr;
      logic wb_ack;
      logic [31:0] wb_dat;
   } seb_state_t;

endpackage : seb_pkg

//--- hw/seb_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module seb_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta;

   // meta is read only by the second stage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta <= RST_VAL;
         q_o <= RST_VAL;
      end else begin
         meta <= d_i;
         q_o <= meta;
      end
   end
endmodule : seb_sync
`default_nettype wire

//--- hw/seb_top.sv
// two-wire serial memory bus slave with 512 byte array and wishbone backdoor
// Operation
// [R1] array of 512 eight-bit locations, all addressable
// [R2] serial clock edges capture and launch bits
// [R3] data line only pulled low or released
// [R4] select bits b3,b2 must equal strap levels
// [R5] open strap input counts as zero
// [R6] five-pin variant fixes expected strap bits zero
// [R7] inhibit high blocks every array modification
// [R8] inhibit low or open permits writes
// [R9] inhibit high: ack select, address; not data
// [R10] silent, no acknowledge while power-on reset
// [R11] reset release leaves logic idle, awaiting start
// [R12] supply loss acts as reset re-asserted
// [R13] standby only after stop, no write pending; code also goes idle on select mismatch or master nack
// [R14] reset clears select, address, counters, fsm
// [R15] select byte: type, straps, top bit, direction
// [R16] match acks on ninth clock, mismatch releases
// [R17] start/stop are data edges while clock high
// [R18] stop after data launches write, bus ignored
`timescale 1ns/100ps
`default_nettype none
module seb_top #(
   parameter int TW_CYCLES = seb_pkg::TW_CYCLES,
   // device type code in the select byte; value is arbitrary
   parameter logic [3:0] TYPE_ID = 4'h6
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // two-wire link
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic strap_select_low_i,
   input wire logic strap_select_high_i,
   input wire logic write_inhibit_i,
   // wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);

   ////////////////////////////////////////////////////////////////////////////
   // functions

   function automatic logic reg_hit(input logic [3:0] adr, input logic [3:0] off);
      reg_hit = (adr[3:2] == off[3:2]);
   endfunction : reg_hit

   // sequential reads run across the whole array and wrap
   function automatic logic [seb_pkg::ADDR_W-1:0] addr_inc(input logic [seb_pkg::ADDR_W-1:0] a);
      addr_inc = a + 9'h001;
   endfunction : addr_inc

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   seb_pkg::seb_pins_t pins_raw;
   seb_pkg::seb_pins_t p;

   assign pins_raw.scl = scl_i;
   assign pins_raw.sda = sda_i;
   assign pins_raw.strap_high = strap_select_high_i;
   assign pins_raw.strap_low = strap_select_low_i;
   assign pins_raw.winh = write_inhibit_i;

   // idle bus is high on both wires so no false start after reset
   seb_sync #(
      .W(5),
      .RST_VAL(5'h18)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(pins_raw),
      .q_o(p)
   );

   ////////////////////////////////////////////////////////////////////////////
   // state and storage

   seb_pkg::seb_state_t s;
   seb_pkg::seb_state_t next_s;
   seb_pkg::seb_state_t rst_s;

   logic [7:0] mem [seb_pkg::MEM_DEPTH];  // [R1]

   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic exp_high;
   logic exp_low;
   logic sel_match;
   logic [7:0] tx_rdata;
   logic [7:0] bd_rdata;
   logic [seb_pkg::PTR_W-1:0] widx;
   logic cyc_we;
   logic bd_we;
   logic wb_req;
   logic bus_busy;
   logic bus_active;

   // clock edges found by sampling the synchronised serial clock
   assign scl_rise = p.scl & ~s.scl_q;  // [R2]
   assign scl_fall = ~p.scl & s.scl_q;  // [R2]
   assign start_seen = p.scl & s.scl_q & s.sda_q & ~p.sda;  // [R17]
   assign stop_seen = p.scl & s.scl_q & ~s.sda_q & p.sda;  // [R17]

   // an open strap is pulled to zero at the pad, so zero is what arrives
   assign exp_high = s.five_pin ? 1'b0 : p.strap_high;  // [R5] [R6]
   assign exp_low = s.five_pin ? 1'b0 : p.strap_low;  // [R5] [R6]

   // select byte is type, two strap bits, top address bit, direction
   assign sel_match = (s.shreg[7:seb_pkg::SEL_TYPE_LSB] == TYPE_ID)
      && (s.shreg[seb_pkg::SEL_CE_HIGH_BIT] == exp_high)
      && (s.shreg[seb_pkg::SEL_CE_LOW_BIT] == exp_low);  // [R4] [R15]

   assign tx_rdata = mem[s.addr];
   assign bd_rdata = mem[s.maddr];

   assign bus_busy = (s.st == seb_pkg::ST_BUSY);
   assign bus_active = (s.st != seb_pkg::ST_IDLE) && !bus_busy;

   // buffered page bytes go to the array in the first cycles of the write time
   assign widx = s.twcnt[seb_pkg::PTR_W-1:0];
   assign cyc_we = bus_busy && (s.twcnt < seb_pkg::TWCNT_W'(seb_pkg::PAGE_BYTES))
      && s.pvalid[widx] && !p.winh;  // [R7] [R8]

   assign wb_req = wb_cyc_i & wb_stb_i & ~s.wb_ack;
   // backdoor writes respect the inhibit too and are dropped during a write cycle
   assign bd_we = wb_req & wb_we_i & wb_sel_i[0] & reg_hit(wb_adr_i, seb_pkg::REG_MDATA)
      & ~bus_busy & ~p.winh;  // [R7]

   ////////////////////////////////////////////////////////////////////////////
   // reset value of the state

   always_comb begin
      rst_s = '0;
      rst_s.st = seb_pkg::ST_IDLE;
      rst_s.kind = seb_pkg::K_SELECT;
      rst_s.scl_q = 1'b1;
      rst_s.sda_q = 1'b1;
      rst_s.sda_drive = 1'b0;
      rst_s.five_pin = seb_pkg::CTRL_FIVE_PIN_RESET;
      rst_s.maddr = seb_pkg::MADDR_RESET;
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      next_s = s;
      next_s.scl_q = p.scl;
      next_s.sda_q = p.sda;
      next_s.sda_level = 1'b0;  // [R3]
      next_s.wb_ack = 1'b0;

      case (s.st)
         seb_pkg::ST_IDLE: begin
            next_s.sda_drive = 1'b0;
         end

         seb_pkg::ST_RX: begin
            if (scl_rise) begin
               next_s.shreg = {s.shreg[6:0], p.sda};  // [R2]
               next_s.bitcnt = s.bitcnt + 4'h1;
               // only the first clock after a data ack may be followed by the stop
               if (s.bitcnt != 4'h0) begin
                  next_s.arm = 1'b0;
               end
            end else if (scl_fall && s.bitcnt == 4'h8) begin
               next_s.bitcnt = 4'h0;
               next_s.st = seb_pkg::ST_ACK;
               case (s.kind)
                  seb_pkg::K_SELECT: begin
                     if (sel_match) begin
                        next_s.ack_ok = 1'b1;  // [R16]
                        next_s.rd = s.shreg[seb_pkg::SEL_DIR_BIT];  // [R15]
                        next_s.addr[8] = s.shreg[seb_pkg::SEL_TOP_BIT];
                     end else begin
                        next_s.ack_ok = 1'b0;
                        next_s.st = seb_pkg::ST_IDLE;  // [R16]
                     end
                  end
                  seb_pkg::K_ADDR: begin
                     next_s.ack_ok = 1'b1;  // [R9]
                     next_s.addr[7:0] = s.shreg;
                     next_s.wptr = s.shreg[seb_pkg::PTR_W-1:0];
                  end
                  default: begin
                     // data byte: buffered for the write cycle unless inhibited
                     next_s.ack_ok = ~p.winh;  // [R9]
                     if (!p.winh) begin
                        next_s.pbuf[s.wptr] = s.shreg;  // [R8]
                        next_s.pvalid[s.wptr] = 1'b1;
                        next_s.wptr = s.wptr + 4'h1;
                     end
                  end
               endcase
               // pull low during the ninth clock only when acknowledging
               next_s.sda_drive = (s.kind == seb_pkg::K_SELECT) ? sel_match :
                  (s.kind == seb_pkg::K_ADDR) ? 1'b1 : ~p.winh;  // [R3] [R16] [R9]
            end
         end

         seb_pkg::ST_ACK: begin
            if (scl_fall) begin
               next_s.sda_drive = 1'b0;
               next_s.bitcnt = 4'h0;
               case (s.kind)
                  seb_pkg::K_SELECT: begin
                     if (s.rd) begin
                        next_s.st = seb_pkg::ST_TX;
                        next_s.shreg = tx_rdata;
                        next_s.sda_drive = ~tx_rdata[7];  // [R2] [R3]
                        next_s.addr = addr_inc(s.addr);
                     end else begin
                        next_s.st = seb_pkg::ST_RX;
                        next_s.kind = seb_pkg::K_ADDR;
                     end
                  end
                  seb_pkg::K_ADDR: begin
                     next_s.st = seb_pkg::ST_RX;
                     next_s.kind = seb_pkg::K_DATA;
                  end
                  default: begin
                     next_s.st = seb_pkg::ST_RX;
                     next_s.arm = s.ack_ok;  // [R18]
                  end
               endcase
            end
         end

         seb_pkg::ST_TX: begin
            if (scl_rise) begin
               next_s.bitcnt = s.bitcnt + 4'h1;
            end else if (scl_fall) begin
               if (s.bitcnt == 4'h8) begin
                  next_s.sda_drive = 1'b0;
                  next_s.st = seb_pkg::ST_MACK;
               end else begin
                  next_s.shreg = {s.shreg[6:0], 1'b0};
                  next_s.sda_drive = ~s.shreg[6];  // [R2] [R3]
               end
            end
         end

         seb_pkg::ST_MACK: begin
            if (scl_rise) begin
               next_s.ack_ok = ~p.sda;
            end else if (scl_fall) begin
               next_s.bitcnt = 4'h0;
               if (s.ack_ok) begin
                  next_s.st = seb_pkg::ST_TX;
                  next_s.shreg = tx_rdata;
                  next_s.sda_drive = ~tx_rdata[7];  // [R3]
                  next_s.addr = addr_inc(s.addr);
               end else begin
                  // master refused the byte: let go and wait for start
                  next_s.st = seb_pkg::ST_IDLE;
               end
            end
         end

         seb_pkg::ST_BUSY: begin
            // the link is not looked at until the write time is over
            next_s.sda_drive = 1'b0;  // [R18]
            if (s.twcnt == seb_pkg::TWCNT_W'(TW_CYCLES - 1)) begin
               next_s.st = seb_pkg::ST_IDLE;  // [R13]
               next_s.addr = {s.addr[8:4], s.wptr};
               next_s.pvalid = '0;
               next_s.twcnt = '0;
            end else begin
               next_s.twcnt = s.twcnt + 1'b1;
            end
         end

         default: begin
            next_s.st = seb_pkg::ST_IDLE;
            next_s.sda_drive = 1'b0;
         end
      endcase

      // start and stop win over the byte machine anywhere outside a write cycle
      if (!bus_busy) begin
         if (start_seen) begin
            next_s.st = seb_pkg::ST_RX;  // [R17]
            next_s.kind = seb_pkg::K_SELECT;
            next_s.bitcnt = 4'h0;
            next_s.sda_drive = 1'b0;
            next_s.arm = 1'b0;
            next_s.pvalid = '0;
         end else if (stop_seen) begin
            next_s.sda_drive = 1'b0;
            next_s.arm = 1'b0;
            if (s.arm && (s.pvalid != '0) && !p.winh) begin
               next_s.st = seb_pkg::ST_BUSY;  // [R18] [R7]
               next_s.twcnt = '0;
            end else begin
               next_s.st = seb_pkg::ST_IDLE;  // [R13]
               next_s.pvalid = '0;
            end
         end
      end

      // wishbone register access, answered one cycle after the request
      if (wb_req) begin
         next_s.wb_ack = 1'b1;
         next_s.wb_dat = 32'h0000_0000;
         if (reg_hit(wb_adr_i, seb_pkg::REG_CTRL)) begin
            if (wb_we_i && wb_sel_i[0]) begin
               next_s.five_pin = wb_dat_i[seb_pkg::CTRL_FIVE_PIN_BIT];  // [R6]
            end
            next_s.wb_dat[seb_pkg::CTRL_FIVE_PIN_BIT] = s.five_pin;
         end else if (reg_hit(wb_adr_i, seb_pkg::REG_STATUS)) begin
            next_s.wb_dat[seb_pkg::STAT_BUSY_BIT] = bus_busy;
            next_s.wb_dat[seb_pkg::STAT_ACTIVE_BIT] = bus_active;
            next_s.wb_dat[seb_pkg::STAT_WINH_BIT] = p.winh;
         end else if (reg_hit(wb_adr_i, seb_pkg::REG_MADDR)) begin
            if (wb_we_i && wb_sel_i[0]) begin
               next_s.maddr[7:0] = wb_dat_i[7:0];
            end
            if (wb_we_i && wb_sel_i[1]) begin
               next_s.maddr[8] = wb_dat_i[8];
            end
            next_s.wb_dat[seb_pkg::ADDR_W-1:0] = s.maddr;
         end else if (reg_hit(wb_adr_i, seb_pkg::REG_MDATA)) begin
            next_s.wb_dat[7:0] = bd_rdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers

   // power-on reset: clears fsm, select, address and counters, data line released
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= rst_s;  // [R10] [R11] [R12] [R14]
      end else begin
         s <= next_s;
      end
   end

   // array write port; the link write cycle has priority over the backdoor
   always_ff @(posedge clk_i) begin
      if (cyc_we) begin
         mem[{s.addr[8:4], widx}] <= s.pbuf[widx];  // [R7] [R1]
      end else if (bd_we) begin
         mem[s.maddr] <= wb_dat_i[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign sda_o = s.sda_level;  // [R3]
   assign sda_oe_o = s.sda_drive;
   assign wb_dat_o = s.wb_dat;
   assign wb_ack_o = s.wb_ack;

endmodule : seb_top
`default_nettype wire

//--- testbench/seb_top_sva.sv
// port checks of the serial memory bus slave
`timescale 1ns/100ps
`default_nettype none
module seb_top_sva (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic scl_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_wb_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_wb_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   // reset itself must be checked, so this one is never disabled
   property p_reset_silent;
      @(posedge clk_i) disable iff (1'b0)
      rst_i |=> !sda_oe_o && !wb_ack_o && wb_dat_o == 32'h0;
   endproperty
   AST_SDA_LOW_ONLY: assert property (!sda_o)
      else $error("data line driven high");
   AST_RESET_SILENT: assert property (p_reset_silent)
      else $error("outputs active during reset");
   AST_RELEASE_IDLE: assert property ($fell(rst_i) |-> !sda_oe_o [*6])
      else $error("data line pulled right after reset");
   // five high samples cover the two-stage synchroniser lag
   AST_SCL_HIGH_HOLD: assert property (scl_i [*5] |-> $stable(sda_oe_o))
      else $error("drive changed while serial clock high");
   AST_DRIVE_SPAN: assert property ($rose(sda_oe_o) |-> sda_oe_o [*6])
      else $error("low drive shorter than a bit");
   AST_WB_ANSWER: assert property (s_wb_req |=> s_wb_pulse)
      else $error("bus answer not a one cycle pulse");
   AST_WB_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i))
      else $error("bus answer without request");
   AST_WB_DAT_HOLD: assert property (!wb_ack_o |-> $stable(wb_dat_o))
      else $error("read data moved outside answer");
endmodule : seb_top_sva
`default_nettype wire

//--- testbench/seb_mst.sv
// two-wire bus master model, owner of the serial clock
`timescale 1ns/100ps
`default_nettype none
module seb_mst (
   output var logic scl_o,
   output var logic pull_o,
   input wire logic sda_i
);
   localparam int Q = 80;
   initial begin
      scl_o = 1'b1; // clock stands high between frames
      pull_o = 1'b0;
   end
   // data moves mid-low and is sampled mid-high, away from both clock edges
   task automatic clk_bit(input logic v, output logic s);
      #Q pull_o = !v;
      #Q scl_o = 1'b1;
      #Q s = sda_i;
      #Q scl_o = 1'b0;
   endtask : clk_bit
   task automatic start_c;
      #Q pull_o = 1'b0;
      #Q scl_o = 1'b1;
      #(2*Q) pull_o = 1'b1; // falling data while clock high
      #(2*Q) scl_o = 1'b0;
   endtask : start_c
   task automatic stop_c;
      #Q pull_o = 1'b1;
      #Q scl_o = 1'b1;
      #(2*Q) pull_o = 1'b0; // rising data while clock high, bus left idle
      #(2*Q);
   endtask : stop_c
   task automatic send(input logic [7:0] b, output logic a);
      logic s;
      for (int i = 7; i >= 0; i--) clk_bit(b[i], s); // msb first
      clk_bit(1'b1, s);
      a = !s;
   endtask : send
   task automatic recv(output logic [7:0] b, input logic mack);
      logic s;
      for (int i = 7; i >= 0; i--) clk_bit(1'b1, b[i]);
      clk_bit(!mack, s);
   endtask : recv
endmodule : seb_mst
`default_nettype wire

//--- testbench/seb_top_test.sv
// self-checking bench of the serial memory bus slave
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
   $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module seb_top_test;
   localparam int TWC = 200;
   localparam logic [3:0] TID = 4'h6; // arbitrary type code
   logic clk_i, rst_i, s_hi, s_lo, winh, cyc, stb, we, sda_o, sda_oe, ack, scl, pull, a;
   logic [3:0] adr, sel;
   logic [31:0] wdat, rdat, q;
   logic [7:0] b;
   int n_errors = 0;
   int checks_done = 0;
   wire logic sda = !(pull || (sda_oe && !sda_o)); // wired-and with pull-up
   seb_top #(.TW_CYCLES(TWC), .TYPE_ID(TID)) seb_top_inst (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl),
      .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe), .strap_select_low_i(s_lo), .strap_select_high_i(s_hi),
      .write_inhibit_i(winh), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
   seb_mst seb_mst_inst (.scl_o(scl), .pull_o(pull), .sda_i(sda));
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = !clk_i;
   end
   task automatic wrap_up;
      if (n_errors == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : wrap_up
   task automatic wb(input logic w, input logic [3:0] ad, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= 4'hf;
      adr <= ad;
      wdat <= d;
      // no answer time is assumed; only the watchdog ends a lost answer
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   function automatic logic [7:0] sb(input logic [1:0] ce, input logic a8, input logic rw);
      return {TID, ce, a8, rw};
   endfunction : sb
   task automatic frame(input logic [7:0] sv);
      // link edges kept 10 ns off the clock edge, so the pin samplers never race them
      @(posedge clk_i);
      #10;
      seb_mst_inst.start_c;
      seb_mst_inst.send(sv, a);
   endtask : frame
   task automatic t_reset;
      wb(1'b0, seb_pkg::REG_CTRL, 32'h0);
      `CHK("ctrl", 32'h0, q)
      wb(1'b0, seb_pkg::REG_STATUS, 32'h0);
      `CHK("status", 32'h0, q)
   endtask : t_reset
   // every strap pattern against every select pattern, both package variants
   task automatic t_straps;
      for (int f = 0; f < 2; f++) begin
         wb(1'b1, seb_pkg::REG_CTRL, 32'(f));
         for (int st = 0; st < 4; st++) begin
            @(posedge clk_i);
            {s_hi, s_lo} <= st[1:0];
            for (int ce = 0; ce < 4; ce++) begin
               frame(sb(ce[1:0], 1'b0, 1'b0));
               seb_mst_inst.stop_c;
               `CHK("sel_ack", (ce == (f ? 0 : st)), a)
            end
         end
      end
      wb(1'b1, seb_pkg::REG_CTRL, 32'h0);
   endtask : t_straps
   task automatic t_write;
      int n = 0;
      @(posedge clk_i);
      {s_hi, s_lo} <= 2'b10;
      frame(sb(2'b10, 1'b1, 1'b0));
      `CHK("sel_ack", 1'b1, a)
      seb_mst_inst.send(8'ha5, a);
      `CHK("addr_ack", 1'b1, a)
      seb_mst_inst.send(8'h3c, a);
      `CHK("data_ack", 1'b1, a)
      seb_mst_inst.stop_c;
      wb(1'b0, seb_pkg::REG_STATUS, 32'h0);
      `CHK("busy", 1'b1, q[seb_pkg::STAT_BUSY_BIT])
      do begin
         frame(sb(2'b10, 1'b1, 1'b0));
         seb_mst_inst.stop_c;
         n++;
      end while (a !== 1'b1 && n < 8);
      `CHK("polls", 1'b1, n > 1 && n < 8)
      wb(1'b1, seb_pkg::REG_MADDR, 32'h1a5);
      wb(1'b0, seb_pkg::REG_MDATA, 32'h0);
      `CHK("mem", 8'h3c, q[7:0])
      wb(1'b1, seb_pkg::REG_MADDR, 32'h1a6);
      wb(1'b1, seb_pkg::REG_MDATA, 32'h5a);
      frame(sb(2'b10, 1'b1, 1'b0));
      seb_mst_inst.send(8'ha5, a);
      frame(sb(2'b10, 1'b1, 1'b1));
      `CHK("rd_ack", 1'b1, a)
      seb_mst_inst.recv(b, 1'b1);
      `CHK("rd_data", 8'h3c, b)
      seb_mst_inst.recv(b, 1'b0);
      seb_mst_inst.stop_c;
      `CHK("rd_next", 8'h5a, b)
   endtask : t_write
   task automatic t_inhibit;
      @(posedge clk_i);
      winh <= 1'b1;
      frame(sb(2'b10, 1'b1, 1'b0));
      `CHK("sel_ack", 1'b1, a)
      seb_mst_inst.send(8'ha5, a);
      `CHK("addr_ack", 1'b1, a)
      for (int i = 0; i < 2; i++) begin
         seb_mst_inst.send(8'h77, a);
         `CHK("data_nack", 1'b0, a)
      end
      seb_mst_inst.stop_c;
      wb(1'b0, seb_pkg::REG_STATUS, 32'h0);
      `CHK("status", 3'b100, q[2:0])
      wb(1'b1, seb_pkg::REG_MDATA, 32'h11);
      wb(1'b0, seb_pkg::REG_MDATA, 32'h0);
      `CHK("mem", 8'h5a, q[7:0])
      wb(1'b1, seb_pkg::REG_MADDR, 32'h1a5);
      wb(1'b0, seb_pkg::REG_MDATA, 32'h0);
      `CHK("mem_link", 8'h3c, q[7:0])
      @(posedge clk_i);
      winh <= 1'b0;
   endtask : t_inhibit
   // supply loss in mid-run: reset raised before a frame and held through it
   task automatic t_por;
      @(posedge clk_i);
      rst_i <= 1'b1;
      frame(sb(2'b10, 1'b0, 1'b0));
      seb_mst_inst.stop_c;
      `CHK("por_nack", 1'b0, a)
      @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (40) @(posedge clk_i);
      wb(1'b0, seb_pkg::REG_MADDR, 32'h0);
      `CHK("maddr", 32'h0, q)
      frame(sb(2'b10, 1'b0, 1'b0));
      seb_mst_inst.stop_c;
      `CHK("sel_ack", 1'b1, a)
   endtask : t_por
   initial begin
      {rst_i, s_hi, s_lo, winh, cyc, stb, we} = 7'h40;
      adr = 4'h0;
      sel = 4'hf;
      wdat = 32'h0;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (40) @(posedge clk_i);
      t_reset;
      t_straps;
      t_write;
      t_inhibit;
      t_por;
      wrap_up;
   end
   initial begin
      #1_000_000;
      n_errors++;
      wrap_up;
   end
endmodule : seb_top_test
bind seb_top seb_top_sva seb_top_sva_inst (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_o(sda_o),
   .sda_oe_o(sda_oe_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
`default_nettype wire
